// ==== logic/smc_sleep_ctrl.sv ====
// sleep mode controller: axi4-lite registers, mode entry, clock gating and wake timing
// assumes a 20 MHz peripheral clock and that wake sources are already synchronous
//
// Overview of operation
// - idle halts cpu, peripherals run, any irq wakes
// - standby gates peripherals by their run-in-standby bits
// - standby keeps analog converter running only with its run-in-standby bit set
// - power-down keeps brownout, watchdog, periodic timer only
// - power-down wakes only on listed sources
// - standby honours listed wakes when run-in-standby set
// - other irqs wake idle only; peripheral clock active/idle
// - rtc clock: idle, standby if set, power-down periodic
// - custom logic wakes power-down only if clockless
// - resume six clocks after oscillator ready
// - idle wake adds no oscillator start-up
// - power-down stops all but low-power and rtc clocks
// - brownout code 3 delays resume until detector ready
// - debug break forces wake to active
// - mode field: 0 idle, 1 standby, 2 power-down
// - sleep only with enable set at sleep instruction
// - wake returns to cpu with state kept
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_sleep_ctrl
  import smc_pkg::*;
(
  input wire logic clk_in, // peripheral clock
  input wire logic resetn_in, // async reset, active low
  input wire logic ce_in, // clock enable, freezes all state when low
  // axi4-lite slave
  input wire logic [7:0] s_awaddr_in,
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  output logic [1:0] s_bresp_out,
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  input wire logic [7:0] s_araddr_in,
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  output logic [31:0] s_rdata_out,
  output logic [1:0] s_rresp_out,
  output logic s_rvalid_out,
  input wire logic s_rready_in,
  // cpu side
  input wire logic sleep_instr_in, // one-cycle pulse: sleep instruction executed
  input wire logic debug_break_in, // debug break level
  output logic cpu_halt_out, // cpu stops executing while high
  output logic cpu_resume_out, // one-cycle pulse: cpu may run its handler
  // wake sources, levels
  input wire logic wake_pin_in, // pin change or external interrupt
  input wire logic wake_twi_in, // two_wire_interface address match
  input wire logic wake_pit_in, // periodic_interrupt_timer
  input wire logic wake_vlm_in, // voltage_level_monitor
  input wire logic wake_ccl_in, // configurable_custom_logic
  input wire logic ccl_needs_clk_in, // custom logic uses an internal clock
  input wire logic wake_rtc_in,
  input wire logic wake_uart_in, // uart start-of-frame
  input wire logic wake_tcb_in, // type_b_timers
  input wire logic wake_adc_in, // analog_converters window
  input wire logic wake_ac_in, // analog_comparators
  input wire logic wake_other_in, // every other interrupt
  // oscillator and brownout status
  input wire logic main_osc_ready_in, // main clock source running and stable
  input wire logic bod_ready_in,
  input wire logic [1:0] bod_active_cfg_in, // brownout active/idle operation setting
  // clock gate enables
  output logic per_clk_en_out, // general peripheral_clock domain
  output logic rtc_en_out,
  output logic ccl_en_out,
  output logic adc_en_out,
  output logic tcb_en_out,
  output logic uart_en_out,
  output logic pit_en_out,
  output logic bod_en_out,
  output logic wdt_en_out,
  output logic main_osc_en_out,
  output logic rtc_osc_en_out,
  output logic ulp_osc_en_out
);
  // run-in-standby bit positions inside the run_in_standby_enable register
  localparam int RS_RTC = 0;
  localparam int RS_CCL = 1;
  localparam int RS_ADC = 2;
  localparam int RS_TCB = 3;
  localparam int RS_UART = 4;
  localparam int RS_AC = 5;

  // all state in one struct
  typedef struct packed {
    smc_state_type st; // controller state
    logic [2:0] ctrl; // mode field and sleep enable
    logic [`SMC_RUN_IN_STANDBY_ENABLE_W-1:0] run_in_standby_enable; // run_in_standby_enable bits
    logic [1:0] mode; // latched mode while asleep
    logic [2:0] cnt; // wake countdown
    logic [`SMC_WAKE_W-1:0] wakes; // count of completed wakes
    logic aw_got; // write address held
    logic w_got; // write data held
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic resume; // resume pulse
  } smc_regs_type;

  smc_regs_type s_r;
  smc_regs_type s_nxt;
  logic wake_any; // gated wake request
  logic asleep; // in a sleep state
  logic eff_idle; // mode behaves as idle
  logic is_sb; // standby
  logic is_pd; // power-down
  logic bod_wait; // resume must wait for brownout

  // mode decode on the latched mode
  always_comb begin
    asleep = (s_r.st == SMC_SLEEP) || (s_r.st == SMC_WAKE);
    is_sb = asleep && (s_r.mode == `SMC_MODE_STANDBY);
    is_pd = asleep && (s_r.mode == `SMC_MODE_POWER_DOWN_CODE);
    eff_idle = asleep && !is_sb && !is_pd; // reserved code acts as idle
    bod_wait = (bod_active_cfg_in == `SMC_BOD_WAIT_CODE);
  end

  // wake source gating per mode
  always_comb begin
    wake_any = 1'b0;
    if (eff_idle) begin
      // any interrupt source wakes idle
      wake_any = wake_pin_in | wake_twi_in | wake_pit_in | wake_vlm_in | wake_ccl_in |
                 wake_rtc_in | wake_uart_in | wake_tcb_in | wake_adc_in | wake_ac_in |
                 wake_other_in;
    end else if (is_sb) begin
      // restricted list plus run-in-standby gated sources
      wake_any = wake_pin_in | wake_twi_in | wake_pit_in | wake_vlm_in |
                 (wake_ccl_in & s_r.run_in_standby_enable[RS_CCL]) | (wake_rtc_in & s_r.run_in_standby_enable[RS_RTC]) |
                 (wake_uart_in & s_r.run_in_standby_enable[RS_UART]) | (wake_tcb_in & s_r.run_in_standby_enable[RS_TCB]) |
                 (wake_adc_in & s_r.run_in_standby_enable[RS_ADC]) | (wake_ac_in & s_r.run_in_standby_enable[RS_AC]);
    end else if (is_pd) begin
      // restricted list, custom logic only when clockless
      wake_any = wake_pin_in | wake_twi_in | wake_pit_in | wake_vlm_in |
                 (wake_ccl_in & !ccl_needs_clk_in);
    end
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.resume = 1'b0;
    // axi write channels, taken in either order
    if (s_awvalid_in && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_awaddr_in;
    end
    if (s_wvalid_in && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_wdata_in;
      s_nxt.wstrb = s_wstrb_in;
    end
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `SMC_RSP_OKAY;
      unique case (s_r.awaddr[7:2])
        6'(`SMC_OFF_CTRL >> 2): begin
          if (s_r.wstrb[0]) begin
            s_nxt.ctrl = s_r.wdata[2:0];
          end
        end
        6'(`SMC_OFF_RUN_IN_STANDBY_ENABLE >> 2): begin
          if (s_r.wstrb[0]) begin
            s_nxt.run_in_standby_enable = s_r.wdata[`SMC_RUN_IN_STANDBY_ENABLE_W-1:0];
          end
        end
        6'(`SMC_OFF_STATUS >> 2): begin
          // status is read-only, writes ignored
        end
        default: begin
          s_nxt.bresp = `SMC_RSP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && s_bready_in) begin
      s_nxt.bvalid = 1'b0;
    end
    // axi read
    if (s_arvalid_in && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `SMC_RSP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      unique case (s_araddr_in[7:2])
        6'(`SMC_OFF_CTRL >> 2): s_nxt.rdata[2:0] = s_r.ctrl;
        6'(`SMC_OFF_RUN_IN_STANDBY_ENABLE >> 2): s_nxt.rdata[`SMC_RUN_IN_STANDBY_ENABLE_W-1:0] = s_r.run_in_standby_enable;
        6'(`SMC_OFF_STATUS >> 2): begin
          s_nxt.rdata[3:0] = s_r.st;
          s_nxt.rdata[5:4] = s_r.mode;
          s_nxt.rdata[16 +: `SMC_WAKE_W] = s_r.wakes;
        end
        default: s_nxt.rresp = `SMC_RSP_SLVERR;
      endcase
    end else if (s_r.rvalid && s_rready_in) begin
      s_nxt.rvalid = 1'b0;
    end
    // sleep sequencer
    unique case (s_r.st)
      SMC_ACTIVE: begin
        // enter only when enabled at the sleep instruction
        if (sleep_instr_in && s_r.ctrl[`SMC_BIT_SEN] && !debug_break_in) begin
          s_nxt.st = SMC_SLEEP;
          s_nxt.mode = s_r.ctrl[`SMC_MODE_LSB +: 2];
        end
      end
      SMC_SLEEP: begin
        // debug break forces a wake
        if (wake_any || debug_break_in) begin
          s_nxt.st = SMC_WAKE;
          s_nxt.cnt = `SMC_WAKE_CYCLES;
        end
      end
      SMC_WAKE: begin
        // count six clocks once the main oscillator runs
        if (main_osc_ready_in && s_r.cnt != 3'h0) begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
        // later of normal wake time and brownout ready
        if (s_r.cnt == 3'h1 && main_osc_ready_in && (!bod_wait || bod_ready_in)) begin
          s_nxt.st = SMC_RESUME;
        end else if (s_r.cnt == 3'h0 && (!bod_wait || bod_ready_in)) begin
          s_nxt.st = SMC_RESUME;
        end
      end
      SMC_RESUME: begin
        // hand back to the cpu, registers and memory untouched
        s_nxt.st = SMC_ACTIVE;
        s_nxt.resume = 1'b1;
        s_nxt.wakes = s_r.wakes + `SMC_WAKE_W'(1);
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
      s_r.st <= SMC_ACTIVE;
      s_r.ctrl <= `SMC_CTRL_RESET;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  // clock gating per mode; waking keeps the sleep gating until resume, except the main oscillator, which runs while waking
  always_comb begin
    cpu_halt_out = s_r.st != SMC_ACTIVE;
    cpu_resume_out = s_r.resume;
    // peripheral clock only active or idle
    per_clk_en_out = !asleep || eff_idle;
    // standby domains by run-in-standby
    rtc_en_out = per_clk_en_out || (is_sb && s_r.run_in_standby_enable[RS_RTC]);
    ccl_en_out = per_clk_en_out || (is_sb && s_r.run_in_standby_enable[RS_CCL]);
    adc_en_out = per_clk_en_out || (is_sb && s_r.run_in_standby_enable[RS_ADC]);
    tcb_en_out = per_clk_en_out || (is_sb && s_r.run_in_standby_enable[RS_TCB]);
    uart_en_out = per_clk_en_out || (is_sb && s_r.run_in_standby_enable[RS_UART]);
    // always-on domains
    pit_en_out = 1'b1;
    bod_en_out = 1'b1;
    wdt_en_out = 1'b1;
    ulp_osc_en_out = 1'b1;
    // main oscillator off in power-down and gated standby
    main_osc_en_out = per_clk_en_out || (is_sb && (|s_r.run_in_standby_enable)) ||
                      (s_r.st == SMC_WAKE);
    // rtc clock source, power-down keeps it for the periodic timer
    rtc_osc_en_out = rtc_en_out || is_pd;
    s_awready_out = !s_r.aw_got && !s_r.bvalid;
    s_wready_out = !s_r.w_got && !s_r.bvalid;
    s_bvalid_out = s_r.bvalid;
    s_bresp_out = s_r.bresp;
    s_arready_out = !s_r.rvalid;
    s_rvalid_out = s_r.rvalid;
    s_rdata_out = s_r.rdata;
    s_rresp_out = s_r.rresp;
  end

  // properties
  property p_enter;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && s_r.st == SMC_ACTIVE && sleep_instr_in && !debug_break_in)
      |=> (cpu_halt_out == s_r.ctrl[`SMC_BIT_SEN]) || $past(!s_r.ctrl[`SMC_BIT_SEN]);
  endproperty
  a_enter: assert property (p_enter) else $error("sleep entry wrong");
  property p_no_enter;
    @(posedge clk_in) disable iff (!resetn_in)
    (s_r.st == SMC_ACTIVE && !s_r.ctrl[`SMC_BIT_SEN]) |=> s_r.st == SMC_ACTIVE;
  endproperty
  a_no_enter: assert property (p_no_enter) else $error("slept without enable");
  property p_break;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && s_r.st == SMC_SLEEP && debug_break_in) |=> s_r.st == SMC_WAKE;
  endproperty
  a_break: assert property (p_break) else $error("debug break ignored");
  property p_pd_other;
    @(posedge clk_in) disable iff (!resetn_in)
    (is_pd && s_r.st == SMC_SLEEP && !debug_break_in && !wake_pin_in && !wake_twi_in &&
     !wake_pit_in && !wake_vlm_in && !wake_ccl_in) |=> s_r.st == SMC_SLEEP;
  endproperty
  a_pd_other: assert property (p_pd_other) else $error("bad power-down wake");
  property p_idle_wake;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && eff_idle && s_r.st == SMC_SLEEP && wake_other_in) |=> s_r.st == SMC_WAKE;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle missed wake");
  property p_six;
    @(posedge clk_in) disable iff (!resetn_in)
    ($rose(s_r.st == SMC_WAKE) && main_osc_ready_in && !bod_wait && ce_in)
      |-> ##6 (s_r.st == SMC_RESUME);
  endproperty
  a_six: assert property (p_six) else $error("wake not six clocks");
  property p_bod;
    @(posedge clk_in) disable iff (!resetn_in)
    (s_r.st == SMC_WAKE && bod_wait && !bod_ready_in) |=> s_r.st != SMC_RESUME;
  endproperty
  a_bod: assert property (p_bod) else $error("resumed before brownout");
  property p_perclk;
    @(posedge clk_in) disable iff (!resetn_in)
    (s_r.st == SMC_SLEEP && s_r.mode != `SMC_MODE_IDLE &&
     s_r.mode != 2'h3) |-> !per_clk_en_out;
  endproperty
  a_perclk: assert property (p_perclk) else $error("peripheral clock in deep sleep");
  property p_pdosc;
    @(posedge clk_in) disable iff (!resetn_in)
    (is_pd && s_r.st == SMC_SLEEP) |-> !main_osc_en_out && rtc_osc_en_out && pit_en_out;
  endproperty
  a_pdosc: assert property (p_pdosc) else $error("power-down clocks wrong");
  property p_resume;
    @(posedge clk_in) disable iff (!resetn_in)
    (ce_in && s_r.st == SMC_RESUME) |=> cpu_resume_out && !cpu_halt_out;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume pulse");
  c_idle: cover property (@(posedge clk_in) eff_idle && s_r.st == SMC_SLEEP);
  c_sb: cover property (@(posedge clk_in) is_sb && s_r.st == SMC_WAKE);
  c_pd: cover property (@(posedge clk_in) is_pd && s_r.st == SMC_WAKE);
  c_res: cover property (@(posedge clk_in) cpu_resume_out);
endmodule

// ==== logic/smc_consts.svh ====
// register offsets, field positions, reset values and timing counts of the sleep controller
// assumes inclusion from the design file only
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
`define SMC_OFF_CTRL 8'h00
`define SMC_OFF_RUN_IN_STANDBY_ENABLE 8'h04
`define SMC_OFF_CFG 8'h08
`define SMC_OFF_STATUS 8'h0C
`define SMC_CTRL_RESET 3'h0
`define SMC_BIT_SEN 0
`define SMC_MODE_LSB 1
`define SMC_MODE_IDLE 2'h0
`define SMC_MODE_STANDBY 2'h1
`define SMC_MODE_POWER_DOWN_CODE 2'h2
`define SMC_WAKE_CYCLES 3'h6
`define SMC_BOD_WAIT_CODE 2'h3
`define SMC_RSP_OKAY 2'h0
`define SMC_RSP_SLVERR 2'h2
`define SMC_RUN_IN_STANDBY_ENABLE_W 6
`define SMC_WAKE_W 14
`endif

// ==== logic/smc_pkg.sv ====
// types shared by the sleep controller design
// assumes smc_consts.svh sits beside it
package smc_pkg;
  // controller states, one-hot
  typedef enum logic [3:0] {
    SMC_ACTIVE = 4'b0001,
    SMC_SLEEP = 4'b0010,
    SMC_WAKE = 4'b0100,
    SMC_RESUME = 4'b1000
  } smc_state_type;
endpackage

// ==== bench/smc_osc_model.sv ====
// main clock source model for the sleep controller bench
// assumes the design's main_osc_en_out feeds osc_en_in, same clock as the design
`timescale 1ns/1ps
module smc_osc_model #(
  parameter int START_CYC = 12 // start-up length, plain default
) (
  input wire logic clk_in, // peripheral clock
  input wire logic resetn_in, // async reset, active low
  input wire logic osc_en_in, // run request from the controller
  output logic osc_ready_out // source running and stable
);
  logic [7:0] cnt_r; // cycles since the last enable
  // a stopped source restarts from zero, a running one stays ready
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= START_CYC[7:0];
    end else if (!osc_en_in) begin
      cnt_r <= 8'h00;
    end else if (cnt_r != START_CYC[7:0]) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // ready only once the start-up count is complete
  assign osc_ready_out = (cnt_r == START_CYC[7:0]);
endmodule

// ==== bench/smc_sleep_ctrl_tb_top.sv ====
// self-checking bench for the sleep controller: axi4-lite tasks and sleep/wake sequences
// assumes the main oscillator model beside it and the design package compiled first
`timescale 1ns/1ps
module smc_sleep_ctrl_tb_top
  import smc_pkg::*;
;
  localparam int OSC = 12; // oscillator start-up cycles of the model
  logic clk_in, resetn_in, sleep_instr_in, ccl_needs_clk_in, bod_ready_in;
  logic [7:0] s_awaddr_in, s_araddr_in; // bus addresses
  logic [31:0] s_wdata_in; // write data
  logic s_awvalid_in, s_wvalid_in, s_bready_in, s_arvalid_in, s_rready_in;
  wire s_awready_out, s_wready_out, s_bvalid_out, s_arready_out, s_rvalid_out;
  wire [1:0] s_bresp_out, s_rresp_out; // responses
  wire [31:0] s_rdata_out; // read data
  wire cpu_halt_out, cpu_resume_out, osc_rdy;
  logic [1:0] bod_active_cfg_in; // brownout setting
  logic [11:0] wk; // wake sources, bit 11 is the debug break
  wire [11:0] ens; // gate enables, per clock first
  int fail_count, samples_checked, n;

  smc_sleep_ctrl dut (
    .clk_in, .resetn_in, .ce_in(1'b1),
    .s_awaddr_in, .s_awvalid_in, .s_awready_out, .s_wdata_in, .s_wstrb_in(4'hF),
    .s_wvalid_in, .s_wready_out, .s_bresp_out, .s_bvalid_out, .s_bready_in,
    .s_araddr_in, .s_arvalid_in, .s_arready_out, .s_rdata_out, .s_rresp_out,
    .s_rvalid_out, .s_rready_in, .sleep_instr_in, .debug_break_in(wk[11]),
    .cpu_halt_out, .cpu_resume_out, .wake_pin_in(wk[0]), .wake_twi_in(wk[1]),
    .wake_pit_in(wk[2]), .wake_vlm_in(wk[3]), .wake_ccl_in(wk[4]), .ccl_needs_clk_in,
    .wake_rtc_in(wk[5]), .wake_uart_in(wk[6]), .wake_tcb_in(wk[7]), .wake_adc_in(wk[8]),
    .wake_ac_in(wk[9]), .wake_other_in(wk[10]), .main_osc_ready_in(osc_rdy),
    .bod_ready_in, .bod_active_cfg_in, .per_clk_en_out(ens[11]), .rtc_en_out(ens[10]),
    .ccl_en_out(ens[9]), .adc_en_out(ens[8]), .tcb_en_out(ens[7]), .uart_en_out(ens[6]),
    .main_osc_en_out(ens[5]), .rtc_osc_en_out(ens[4]), .pit_en_out(ens[3]),
    .bod_en_out(ens[2]), .wdt_en_out(ens[1]), .ulp_osc_en_out(ens[0])
  );

  smc_osc_model #(.START_CYC(OSC)) osc (
    .clk_in, .resetn_in, .osc_en_in(ens[5]), .osc_ready_out(osc_rdy)
  );

  // 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk_in);
    s_awaddr_in <= a;
    s_wdata_in <= d;
    s_awvalid_in <= 1'b1;
    s_wvalid_in <= 1'b1;
    s_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_awvalid_in && s_awready_out) s_awvalid_in <= 1'b0;
      if (s_wvalid_in && s_wready_out) s_wvalid_in <= 1'b0;
      k++;
    end while (!s_bvalid_out && k < 50);
    s_bready_in <= 1'b0;
    chk({s_bvalid_out, s_bresp_out}, {1'b1, er});
  endtask

  // bus read with mask on the returned word
  task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk_in);
    s_araddr_in <= a;
    s_arvalid_in <= 1'b1;
    s_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_arvalid_in && s_arready_out) s_arvalid_in <= 1'b0;
      k++;
    end while (!s_rvalid_out && k < 50);
    s_rready_in <= 1'b0;
    chk({s_rvalid_out, s_rresp_out}, {1'b1, er});
    chk(s_rdata_out & m, e);
  endtask

  // program the control word, then one sleep instruction pulse
  task automatic slp(input logic [31:0] ctl);
    axw(8'h00, ctl, 2'h0);
    @(posedge clk_in);
    sleep_instr_in <= 1'b1;
    @(posedge clk_in);
    sleep_instr_in <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask

  // raise wake sources and count cycles until the resume pulse
  task automatic wake(input logic [11:0] w, output int c);
    @(posedge clk_in);
    wk <= w;
    c = 0;
    do begin
      @(posedge clk_in);
      #1;
      c++;
    end while (!cpu_resume_out && c < 400);
    chk(cpu_halt_out, 32'h0);
    @(posedge clk_in);
    wk <= 12'h000;
  endtask

  // hold sources that must not wake, device stays halted
  task automatic ign(input logic [11:0] w);
    @(posedge clk_in);
    wk <= w;
    repeat (10) @(posedge clk_in);
    #1;
    chk(cpu_halt_out, 32'h1);
    @(posedge clk_in);
    wk <= 12'h000;
  endtask

  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    resetn_in = 1'b0;
    s_awaddr_in = 8'h00;
    s_araddr_in = 8'h00;
    s_wdata_in = 32'h0;
    s_awvalid_in = 1'b0;
    s_wvalid_in = 1'b0;
    s_bready_in = 1'b0;
    s_arvalid_in = 1'b0;
    s_rready_in = 1'b0;
    sleep_instr_in = 1'b0;
    ccl_needs_clk_in = 1'b1;
    bod_ready_in = 1'b0;
    bod_active_cfg_in = 2'h0;
    wk = 12'h000;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    axr(8'h00, 32'hFF, 32'h0, 2'h0);
    axw(8'h00, 32'hFF, 2'h0);
    axr(8'h00, 32'hFF, 32'h7, 2'h0);
    axw(8'h04, 32'h3F, 2'h0);
    axr(8'h04, 32'hFF, 32'h3F, 2'h0);
    axw(8'h08, 32'h1, 2'h2);
    axr(8'h08, 32'h0, 32'h0, 2'h2);
    $display("test registers done");
    slp(32'h0);
    chk(cpu_halt_out, 32'h0);
    $display("test sleep disabled done");
    slp(32'h1);
    chk(cpu_halt_out, 32'h1);
    chk(ens, 32'hFFF);
    wake(12'h400, n);
    chk(n, 32'h8);
    $display("test idle done");
    axw(8'h04, 32'h05, 2'h0);
    slp(32'h3);
    chk(ens, 32'h53F);
    axr(8'h0C, 32'h3F, 32'h12, 2'h0);
    ign(12'h6C0);
    wake(12'h020, n);
    chk(n, 32'h8);
    axw(8'h04, 32'h3F, 2'h0);
    for (int i = 5; i < 10; i++) begin
      slp(32'h3);
      wake(12'h001 << i, n);
      chk(n, 32'h8);
    end
    $display("test standby done");
    slp(32'h5);
    chk(ens, 32'h01F);
    ign(12'h7F0);
    @(posedge clk_in);
    ccl_needs_clk_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (i > 0) slp(32'h5);
      wake(12'h010 >> i, n);
      chk(n >= OSC + 8 && n <= OSC + 9, 32'h1);
    end
    $display("test power-down done");
    @(posedge clk_in);
    bod_active_cfg_in <= 2'h3;
    slp(32'h1);
    ign(12'h001);
    @(posedge clk_in);
    bod_ready_in <= 1'b1;
    wake(12'h000, n);
    chk(n <= 2, 32'h1);
    $display("test brownout wait done");
    @(posedge clk_in);
    bod_active_cfg_in <= 2'h0;
    slp(32'h7);
    chk(ens, 32'hFFF);
    wake(12'h800, n);
    chk(n, 32'h8);
    $display("test reserved and debug done");
    report_and_stop();
  end

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    report_and_stop();
  end
endmodule
